// ===== core/srd_dwell.sv
// Purpose: One dwell timer channel carried by an alarm
// Assumes: minute_tick is a one-cycle pulse
// Notes: Output latches until clear or loss of dwell function
`timescale 1ns/100ps
module srd_dwell (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic enable,
  input wire logic reached,
  input wire logic minute_tick,
  input wire logic [15:0] duration,
  input wire logic clear,
  // Result
  output logic expired
);
  typedef enum logic [2:0] {
    DW_IDLE = 3'b001,
    DW_COUNT = 3'b010,
    DW_DONE = 3'b100
  } srd_dwell_state_t;

  srd_dwell_state_t state_reg;
  logic [15:0] elapsed_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= DW_IDLE;
      elapsed_reg <= 16'h0000;
    end
    else
    begin
      case (state_reg)
        DW_IDLE:
        begin
          elapsed_reg <= 16'h0000;
          if (enable && reached && !clear)
            state_reg <= DW_COUNT;
        end
        DW_COUNT:
        begin
          // Live duration compare: an edit applies without a restart
          if (!enable || clear)
            state_reg <= DW_IDLE;
          else if (elapsed_reg >= duration)
            state_reg <= DW_DONE;
          else if (minute_tick)
            elapsed_reg <= elapsed_reg + 16'h0001;
        end
        DW_DONE:
        begin
          if (!enable || clear)
            state_reg <= DW_IDLE;
        end
        default:
          state_reg <= DW_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      expired <= 1'b0;
    else
      expired <= (state_reg == DW_DONE) && enable && !clear;
  end
endmodule : srd_dwell

// ===== core/srd_pkg.sv
// Purpose: Constants and types for the set-point block
// Assumes: 100 MHz pclk, APB register access
// Notes: All offsets are byte addresses of 32-bit words
package srd_pkg;
  // Timing
  localparam int unsigned SEC_CYCLES = 100_000_000;
  localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3C;
  localparam logic [5:0] MINUTES_PER_HOUR = 6'h3C;
  // Register map
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_SETPOINT = 8'h04;
  localparam logic [7:0] ADDR_RAMP_RATE = 8'h08;
  localparam logic [7:0] ADDR_DWELL = 8'h0C;
  localparam logic [7:0] ADDR_LIMITS = 8'h10;
  localparam logic [7:0] ADDR_COMM = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_RAMP_VALUE = 8'h1C;
  localparam logic [7:0] ADDR_PROCESS = 8'h20;
  // Reset values and limits
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [15:0] COMM_RST = 16'h0001;
  localparam logic [6:0] LIMIT_RST = 7'h64;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam logic [7:0] MAX_UNIT_ADDR = 8'hF7;
  // Field positions
  localparam int HEAT_LIM_LSB = 0;
  localparam int COOL_LIM_LSB = 8;
  localparam int ERR_DWELL_BOTH = 0;
  localparam int ERR_SAME_INPUT = 1;
  localparam int ERR_DIFF_REMOTE = 2;
  localparam int ERR_DIFF_UNITS = 3;

  typedef enum logic [2:0] {
    SP_LOCAL = 3'h0,
    SP_PER_MINUTE = 3'h1,
    SP_PER_HOUR = 3'h2,
    SP_INPUT_ONE = 3'h3,
    SP_INPUT_TWO = 3'h4
  } srd_sp_src_t;

  typedef enum logic [1:0] {
    PV_INPUT_ONE = 2'h0,
    PV_INPUT_TWO = 2'h1,
    PV_DIFF_FIRST_MINUS_SECOND = 2'h2,
    PV_DIFF_SECOND_MINUS_FIRST = 2'h3
  } srd_pv_src_t;

  localparam logic [1:0] ALARM_PROCESS = 2'h0;
  localparam logic [1:0] ALARM_DWELL = 2'h1;
  localparam logic [3:0] EV_CLEAR_ONE = 4'h4;
  localparam logic [3:0] EV_CLEAR_TWO = 4'h5;
  localparam logic [3:0] EV_CLEAR_BOTH = 4'h6;

  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic [1:0] input_two_decimals;
    logic [1:0] input_one_decimals;
    logic [1:0] input_two_units;
    logic [1:0] input_one_units;
    logic [3:0] event_input_function;
    logic point_to_point_link;
    logic feature_full;
    logic on_off_control;
    logic output_two_cooling;
    logic [1:0] alarm_two_function;
    logic [1:0] alarm_one_function;
    logic [1:0] rsvd_mid;
    srd_pv_src_t process_value_source;
    logic rsvd_lo;
    srd_sp_src_t setpoint_source_select;
  } srd_cfg_t;

  typedef struct packed {
    logic two_stop_bits;
    logic [1:0] parity_setting;
    logic seven_data_bits;
    logic [3:0] baud_select;
    logic [7:0] unit_address;
  } srd_comm_t;
endpackage : srd_pkg

// ===== core/srd_sync3.sv
// Purpose: Three-stage synchroniser for a pin input
// Assumes: Pin may change at any time relative to pclk
// Notes: Output follows once stages two and three agree
`timescale 1ns/100ps
module srd_sync3 (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and result
  input wire logic pin_in,
  output logic level_out
);
  logic s1_reg, s2_reg, s3_reg;

  // Agreement filter rejects single-cycle metastable glitches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level_out <= s3_reg;
    end
  end
endmodule : srd_sync3

// ===== core/srd_top.sv
// Purpose: Set-point ramp, dwell timers, input routing, power limits, config checks
// Assumes: Input values arrive synchronous to pclk; event and key are raw pins
// Notes: APB slave answers in the first cycle of the access phase
`timescale 1ns/100ps
// Behaviour
// - Ramp at power-up and on setpoint change
// - Rate per minute or per hour
// - Ramp value loads process value on change
// - Zero rate applies setpoint at once
// - Display ramp value, setpoint after key
// - Alarm channel may act as dwell timer
// - Dwell counts from setpoint reached, then alarms
// - Duration edits apply without restart
// - Dwell output latched until event clear or dwell function off
// - Both channels dwell flags error
// - Remote setpoint takes other input as process
// - Same input for both sources flags error
// - Differential process value either direction
// - Differential with remote setpoint flags error
// - Differential with mismatched units flags error
// - Cool limit hidden unless cooling, both limits off for on-off
// - Limits 0 to 100 percent cap outputs
// - Manual or failure values are not limited
// - Select multi-drop or point-to-point link
// - Unit answers its own programmed address
// - Addresses up to 247, line format configurable
// - Remote, differential, comms need full features
// - Event clears alarm one, alarm two or both while asserted
module srd_top #(
  parameter int unsigned SEC_CYCLES = srd_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Process side
  input wire logic [15:0] input_one_value,
  input wire logic [15:0] input_two_value,
  input wire logic [6:0] heat_manipulated_value,
  input wire logic [6:0] cool_manipulated_value,
  input wire logic manual_or_failure,
  input wire logic alarm_one_condition,
  input wire logic alarm_two_condition,
  // Pins
  input wire logic event_input_pin,
  input wire logic key_adjust_pin,
  // Control results
  output logic [15:0] process_value,
  output logic [15:0] control_setpoint,
  output logic [15:0] display_value,
  output logic [6:0] heat_power_out,
  output logic [6:0] cool_power_out,
  output logic alarm_one_out,
  output logic alarm_two_out,
  output logic [3:0] config_error,
  // Serial link setup
  output logic comm_enable,
  output logic link_point_to_point,
  output logic [7:0] unit_address,
  output logic [7:0] line_format
);
  srd_pkg::srd_cfg_t cfg_reg;
  srd_pkg::srd_comm_t comm_reg;
  logic [15:0] setpoint_reg, ramp_rate_reg, dwell_time_reg, ramp_reg, pv_next, sp_next;
  logic [6:0] heat_limit_reg, cool_limit_reg, wr_heat, wr_cool;
  logic [31:0] sec_cnt_reg, rd_data;
  logic [5:0] sec_in_min_reg, min_in_hour_reg;
  logic [1:0] dwell_expired;
  logic load_pend_reg, show_sp_reg, key_prev_reg, minute_tick, hour_tick, sec_tick;
  logic event_level, key_level, rd_hit, wr_en, ramp_mode, ramping, remote_one, remote_two;
  logic pv_diff, step_tick, clear_one, clear_two, reached, cool_visible, heat_visible;
  logic signed [16:0] gap, rate_s;

  srd_sync3 u_event_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(event_input_pin),
    .level_out(event_level)
  );

  srd_sync3 u_key_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(key_adjust_pin),
    .level_out(key_level)
  );

  // Mode decode
  assign ramp_mode = (cfg_reg.setpoint_source_select == srd_pkg::SP_PER_MINUTE) ||
                     (cfg_reg.setpoint_source_select == srd_pkg::SP_PER_HOUR);
  assign ramping = ramp_mode && (ramp_rate_reg != 16'h0000);
  assign remote_one = cfg_reg.feature_full &&
                      (cfg_reg.setpoint_source_select == srd_pkg::SP_INPUT_ONE);
  assign remote_two = cfg_reg.feature_full &&
                      (cfg_reg.setpoint_source_select == srd_pkg::SP_INPUT_TWO);
  assign pv_diff = cfg_reg.feature_full && cfg_reg.process_value_source[1];
  assign step_tick = (cfg_reg.setpoint_source_select == srd_pkg::SP_PER_HOUR) ?
                     hour_tick : minute_tick;
  assign wr_en = psel && penable && pwrite && pready;
  assign clear_one = event_level &&
                     ((cfg_reg.event_input_function == srd_pkg::EV_CLEAR_ONE) ||
                      (cfg_reg.event_input_function == srd_pkg::EV_CLEAR_BOTH));
  assign clear_two = event_level &&
                     ((cfg_reg.event_input_function == srd_pkg::EV_CLEAR_TWO) ||
                      (cfg_reg.event_input_function == srd_pkg::EV_CLEAR_BOTH));
  assign reached = $signed(process_value) >= $signed(control_setpoint);
  assign heat_visible = !cfg_reg.on_off_control;
  assign cool_visible = cfg_reg.output_two_cooling && !cfg_reg.on_off_control;

  // Process value routing
  always_comb
  begin
    pv_next = input_one_value;
    if (remote_one)
      pv_next = input_two_value;
    else if (remote_two)
      pv_next = input_one_value;
    else if (pv_diff && !cfg_reg.process_value_source[0])
      pv_next = 16'(input_one_value - input_two_value);
    else if (pv_diff)
      pv_next = 16'(input_two_value - input_one_value);
    else if (cfg_reg.process_value_source == srd_pkg::PV_INPUT_TWO)
      pv_next = input_two_value;
  end

  // Active set point selection
  always_comb
  begin
    sp_next = setpoint_reg;
    if (remote_one)
      sp_next = input_one_value;
    else if (remote_two)
      sp_next = input_two_value;
    else if (ramping)
      sp_next = ramp_reg;
  end

  // Time base: seconds, then minutes and hours
  assign sec_tick = (sec_cnt_reg == 32'(SEC_CYCLES - 1));
  assign minute_tick = sec_tick && (sec_in_min_reg == srd_pkg::SECONDS_PER_MINUTE - 6'h01);
  assign hour_tick = minute_tick &&
                     (min_in_hour_reg == srd_pkg::MINUTES_PER_HOUR - 6'h01);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_cnt_reg <= 32'h0000_0000;
      sec_in_min_reg <= 6'h00;
      min_in_hour_reg <= 6'h00;
    end
    else
    begin
      sec_cnt_reg <= sec_tick ? 32'h0000_0000 : sec_cnt_reg + 32'h0000_0001;
      if (minute_tick)
        sec_in_min_reg <= 6'h00;
      else if (sec_tick)
        sec_in_min_reg <= sec_in_min_reg + 6'h01;
      if (hour_tick)
        min_in_hour_reg <= 6'h00;
      else if (minute_tick)
        min_in_hour_reg <= min_in_hour_reg + 6'h01;
    end
  end

  // Configuration registers
  assign wr_heat = (pwdata[srd_pkg::HEAT_LIM_LSB +: 7] > srd_pkg::PCT_MAX) ?
                   srd_pkg::PCT_MAX : pwdata[srd_pkg::HEAT_LIM_LSB +: 7];
  assign wr_cool = (pwdata[srd_pkg::COOL_LIM_LSB +: 7] > srd_pkg::PCT_MAX) ?
                   srd_pkg::PCT_MAX : pwdata[srd_pkg::COOL_LIM_LSB +: 7];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_reg <= srd_pkg::CFG_RST;
      comm_reg <= srd_pkg::COMM_RST;
      setpoint_reg <= 16'h0000;
      ramp_rate_reg <= 16'h0000;
      dwell_time_reg <= 16'h0000;
      heat_limit_reg <= srd_pkg::LIMIT_RST;
      cool_limit_reg <= srd_pkg::LIMIT_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        srd_pkg::ADDR_CFG: cfg_reg <= pwdata;
        srd_pkg::ADDR_SETPOINT: setpoint_reg <= pwdata[15:0];
        srd_pkg::ADDR_RAMP_RATE: ramp_rate_reg <= pwdata[15:0];
        srd_pkg::ADDR_DWELL: dwell_time_reg <= pwdata[15:0];
        srd_pkg::ADDR_LIMITS:
        begin
          // Hidden limits ignore writes
          if (heat_visible)
            heat_limit_reg <= wr_heat;
          if (cool_visible)
            cool_limit_reg <= wr_cool;
        end
        srd_pkg::ADDR_COMM:
        begin
          comm_reg <= pwdata[15:0];
          // Address outside 1..247 keeps the old one
          if (pwdata[7:0] == 8'h00 || pwdata[7:0] > srd_pkg::MAX_UNIT_ADDR)
            comm_reg.unit_address <= comm_reg.unit_address;
        end
        default: ;
      endcase
    end
  end

  // Ramp reload after reset or any retarget
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      load_pend_reg <= 1'b1;
    else
      load_pend_reg <= wr_en && (paddr == srd_pkg::ADDR_SETPOINT ||
        paddr == srd_pkg::ADDR_RAMP_RATE || paddr == srd_pkg::ADDR_CFG);
  end

  assign gap = $signed({setpoint_reg[15], setpoint_reg}) - $signed({ramp_reg[15], ramp_reg});
  assign rate_s = $signed({1'b0, ramp_rate_reg});

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ramp_reg <= 16'h0000;
    else if (load_pend_reg)
      ramp_reg <= pv_next;
    else if (ramping && step_tick && (ramp_reg != setpoint_reg))
    begin
      if (gap > rate_s)
        ramp_reg <= ramp_reg + ramp_rate_reg;
      else if (gap < -rate_s)
        ramp_reg <= ramp_reg - ramp_rate_reg;
      else
        ramp_reg <= setpoint_reg;
    end
  end

  // Key returns display to set point until next load
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_prev_reg <= 1'b0;
      show_sp_reg <= 1'b0;
    end
    else
    begin
      key_prev_reg <= key_level;
      if (key_level && !key_prev_reg)
        show_sp_reg <= 1'b1;
      else if (load_pend_reg)
        show_sp_reg <= 1'b0;
    end
  end

  // Dwell timers, one per alarm channel
  srd_dwell u_dwell_one (
    .pclk(pclk),
    .presetn(presetn),
    .enable(cfg_reg.alarm_one_function == srd_pkg::ALARM_DWELL),
    .reached(reached),
    .minute_tick(minute_tick),
    .duration(dwell_time_reg),
    .clear(clear_one),
    .expired(dwell_expired[0])
  );

  srd_dwell u_dwell_two (
    .pclk(pclk),
    .presetn(presetn),
    .enable(cfg_reg.alarm_two_function == srd_pkg::ALARM_DWELL),
    .reached(reached),
    .minute_tick(minute_tick),
    .duration(dwell_time_reg),
    .clear(clear_two),
    .expired(dwell_expired[1])
  );

  // Control, alarm and link outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      process_value <= 16'h0000;
      control_setpoint <= 16'h0000;
      display_value <= 16'h0000;
      heat_power_out <= 7'h00;
      cool_power_out <= 7'h00;
      alarm_one_out <= 1'b0;
      alarm_two_out <= 1'b0;
      comm_enable <= 1'b0;
      link_point_to_point <= 1'b0;
      unit_address <= 8'h00;
      line_format <= 8'h00;
    end
    else
    begin
      process_value <= pv_next;
      control_setpoint <= sp_next;
      display_value <= (ramping && !show_sp_reg) ? ramp_reg : setpoint_reg;
      if (manual_or_failure || !heat_visible)
        heat_power_out <= heat_manipulated_value;
      else
        heat_power_out <= (heat_manipulated_value > heat_limit_reg) ?
                          heat_limit_reg : heat_manipulated_value;
      if (manual_or_failure || !cool_visible)
        cool_power_out <= cool_manipulated_value;
      else
        cool_power_out <= (cool_manipulated_value > cool_limit_reg) ?
                          cool_limit_reg : cool_manipulated_value;
      alarm_one_out <= (cfg_reg.alarm_one_function == srd_pkg::ALARM_DWELL) ?
                       dwell_expired[0] : (alarm_one_condition && !clear_one);
      alarm_two_out <= (cfg_reg.alarm_two_function == srd_pkg::ALARM_DWELL) ?
                       dwell_expired[1] : (alarm_two_condition && !clear_two);
      comm_enable <= cfg_reg.feature_full;
      link_point_to_point <= cfg_reg.point_to_point_link;
      unit_address <= comm_reg.unit_address;
      line_format <= comm_reg[15:8];
    end
  end

  // Configuration checks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      config_error <= 4'h0;
    else
    begin
      config_error[srd_pkg::ERR_DWELL_BOTH] <=
        (cfg_reg.alarm_one_function == srd_pkg::ALARM_DWELL) &&
        (cfg_reg.alarm_two_function == srd_pkg::ALARM_DWELL);
      config_error[srd_pkg::ERR_SAME_INPUT] <=
        ((cfg_reg.setpoint_source_select == srd_pkg::SP_INPUT_ONE) &&
         (cfg_reg.process_value_source == srd_pkg::PV_INPUT_ONE)) ||
        ((cfg_reg.setpoint_source_select == srd_pkg::SP_INPUT_TWO) &&
         (cfg_reg.process_value_source == srd_pkg::PV_INPUT_TWO));
      config_error[srd_pkg::ERR_DIFF_REMOTE] <= cfg_reg.process_value_source[1] &&
        ((cfg_reg.setpoint_source_select == srd_pkg::SP_INPUT_ONE) ||
         (cfg_reg.setpoint_source_select == srd_pkg::SP_INPUT_TWO));
      config_error[srd_pkg::ERR_DIFF_UNITS] <= cfg_reg.process_value_source[1] &&
        ((cfg_reg.input_one_units != cfg_reg.input_two_units) ||
         (cfg_reg.input_one_decimals != cfg_reg.input_two_decimals));
    end
  end

  // APB read mux
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      srd_pkg::ADDR_CFG: rd_data = cfg_reg;
      srd_pkg::ADDR_SETPOINT: rd_data = {16'h0000, setpoint_reg};
      srd_pkg::ADDR_RAMP_RATE: rd_data = {16'h0000, ramp_rate_reg};
      srd_pkg::ADDR_DWELL: rd_data = {16'h0000, dwell_time_reg};
      srd_pkg::ADDR_LIMITS:
        rd_data = {17'h0_0000, cool_visible ? cool_limit_reg : 7'h00,
                   1'b0, heat_visible ? heat_limit_reg : 7'h00};
      srd_pkg::ADDR_COMM: rd_data = {16'h0000, comm_reg};
      srd_pkg::ADDR_STATUS:
        rd_data = {22'h00_0000, dwell_expired, show_sp_reg, alarm_two_out,
                   alarm_one_out, ramping, config_error};
      srd_pkg::ADDR_RAMP_VALUE: rd_data = {16'h0000, ramp_reg};
      srd_pkg::ADDR_PROCESS: rd_data = {control_setpoint, process_value};
      default: rd_hit = 1'b0;
    endcase
  end

  // Answer prepared in setup, presented in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata <= pwrite ? 32'h0000_0000 : rd_data;
      pready <= 1'b1;
      pslverr <= !rd_hit;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule : srd_top

// ===== tb/setpoint_ramp_dwell_config_tb.sv
// Purpose: Self-checking bench for srd_top
// Assumes: SEC_CYCLES of 4 gives 240-cycle minutes
// Notes: Plant model drives input one
`timescale 1ns/100ps
module setpoint_ramp_dwell_config_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic pready, pslverr, rerr, ld = 1'b0, manual_or_failure = 1'b0;
  logic alarm_one_condition = 1'b0, alarm_two_condition = 1'b0;
  logic event_input_pin = 1'b0, key_adjust_pin = 1'b0;
  logic [15:0] lv = 16'h0000, input_one_value, input_two_value = 16'h001E;
  logic [6:0] heat_manipulated_value = 7'h00, cool_manipulated_value = 7'h00;
  logic [15:0] process_value, control_setpoint, display_value;
  logic [6:0] heat_power_out, cool_power_out;
  logic alarm_one_out, alarm_two_out, comm_enable, link_point_to_point;
  logic [3:0] config_error;
  logic [7:0] unit_address, line_format;
  srd_pkg::srd_cfg_t c;
  int fails = 0, comparisons = 0, cyc = 0;
  srd_top #(.SEC_CYCLES(4)) DUT (.*);
  srd_plant u_plant (.pclk(pclk), .presetn(presetn), .load(ld), .load_val(lv),
    .heat(heat_power_out), .pv(input_one_value));
  always #5 pclk = ~pclk;
  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Two idle edges: written values reach the outputs before a check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : apb
  task automatic setc(input srd_pkg::srd_sp_src_t sp, input srd_pkg::srd_pv_src_t pv);
    c.setpoint_source_select = sp;
    c.process_value_source = pv;
    apb(1'b1, srd_pkg::ADDR_CFG, c);
    repeat (3) @(posedge pclk);
  endtask : setc
  task automatic setpv(input logic [15:0] v);
    ld <= 1'b1;
    lv <= v;
    @(posedge pclk);
    ld <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : setpv
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, srd_pkg::ADDR_LIMITS, 32'h0000_0000);
    chk(rdat, 32'h0000_0064);
    apb(1'b0, srd_pkg::ADDR_COMM, 32'h0000_0000);
    chk(rdat, 32'h0000_0001);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({rerr, rdat[30:0]}, 32'h8000_0000);
    apb(1'b1, srd_pkg::ADDR_COMM, 32'h0000_00F8);
    chk(unit_address, 8'h01);
    apb(1'b1, srd_pkg::ADDR_COMM, 32'h0000_00F7);
    chk(unit_address, 8'hF7);
    c = '0;
    c.feature_full = 1'b1;
    c.alarm_one_function = srd_pkg::ALARM_DWELL;
    c.alarm_two_function = srd_pkg::ALARM_DWELL;
    setc(srd_pkg::SP_LOCAL, srd_pkg::PV_INPUT_ONE);
    chk(config_error, 4'h1);
    c.alarm_one_function = srd_pkg::ALARM_PROCESS;
    setc(srd_pkg::SP_INPUT_ONE, srd_pkg::PV_INPUT_ONE);
    chk(config_error, 4'h2);
    setc(srd_pkg::SP_INPUT_TWO, srd_pkg::PV_INPUT_TWO);
    chk(config_error, 4'h2);
    setc(srd_pkg::SP_INPUT_ONE, srd_pkg::PV_DIFF_FIRST_MINUS_SECOND);
    chk(config_error, 4'h4);
    c.input_two_units = 2'h1;
    setc(srd_pkg::SP_LOCAL, srd_pkg::PV_DIFF_SECOND_MINUS_FIRST);
    chk(config_error, 4'h8);
    c.input_two_units = 2'h0;
    c.point_to_point_link = 1'b1;
    setpv(16'h0064);
    setc(srd_pkg::SP_INPUT_TWO, srd_pkg::PV_INPUT_ONE);
    chk({process_value, control_setpoint}, 32'h0064_001E);
    chk({comm_enable, link_point_to_point}, 2'h3);
    setc(srd_pkg::SP_INPUT_ONE, srd_pkg::PV_INPUT_TWO);
    chk({process_value, control_setpoint}, 32'h001E_0064);
    setc(srd_pkg::SP_LOCAL, srd_pkg::PV_DIFF_FIRST_MINUS_SECOND);
    chk(process_value, 16'h0046);
    setc(srd_pkg::SP_LOCAL, srd_pkg::PV_DIFF_SECOND_MINUS_FIRST);
    chk(process_value, 16'hFFBA);
    setpv(16'h000A);
    apb(1'b1, srd_pkg::ADDR_RAMP_RATE, 32'h0000_0005);
    apb(1'b1, srd_pkg::ADDR_SETPOINT, 32'h0000_001E);
    setc(srd_pkg::SP_PER_MINUTE, srd_pkg::PV_INPUT_ONE);
    chk(display_value, 16'h000A);
    for (int k = 1; k < 5; k++)
    begin
      for (int i = 0; i < 300 && display_value === 16'(5 + 5 * k); i++)
        @(posedge pclk);
      chk(display_value, 16'(10 + 5 * k));
    end
    repeat (300) @(posedge pclk);
    chk(display_value, 16'h001E);
    setc(srd_pkg::SP_PER_HOUR, srd_pkg::PV_INPUT_ONE);
    repeat (300) @(posedge pclk);
    chk(display_value, 16'h000A);
    key_adjust_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    key_adjust_pin <= 1'b0;
    chk(display_value, 16'h001E);
    apb(1'b1, srd_pkg::ADDR_RAMP_RATE, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    apb(1'b0, srd_pkg::ADDR_STATUS, 32'h0000_0000);
    chk({rdat[4], control_setpoint}, 17'h0_001E);
    c.alarm_one_function = srd_pkg::ALARM_DWELL;
    c.alarm_two_function = srd_pkg::ALARM_PROCESS;
    c.event_input_function = srd_pkg::EV_CLEAR_ONE;
    apb(1'b1, srd_pkg::ADDR_DWELL, 32'h0000_0002);
    setc(srd_pkg::SP_LOCAL, srd_pkg::PV_INPUT_ONE);
    setpv(16'h0014);
    chk(alarm_one_out, 1'b0);
    // Reached at 60; 2 minutes would end by 481 cycles, 4 not before 721
    setpv(16'h003C);
    repeat (100) @(posedge pclk);
    apb(1'b1, srd_pkg::ADDR_DWELL, 32'h0000_0004);
    repeat (480) @(posedge pclk);
    chk(alarm_one_out, 1'b0);
    for (int i = 0; i < 600 && alarm_one_out !== 1'b1; i++)
      @(posedge pclk);
    chk(alarm_one_out, 1'b1);
    setpv(16'h0000);
    repeat (20) @(posedge pclk);
    chk(alarm_one_out, 1'b1);
    event_input_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(alarm_one_out, 1'b0);
    event_input_pin <= 1'b0;
    c.output_two_cooling = 1'b1;
    setc(srd_pkg::SP_LOCAL, srd_pkg::PV_INPUT_ONE);
    apb(1'b1, srd_pkg::ADDR_LIMITS, 32'h0000_1E32);
    heat_manipulated_value <= 7'h50;
    cool_manipulated_value <= 7'h5A;
    repeat (3) @(posedge pclk);
    chk({heat_power_out, cool_power_out}, 14'h191E);
    manual_or_failure <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(heat_power_out, 7'h50);
    manual_or_failure <= 1'b0;
    apb(1'b1, srd_pkg::ADDR_LIMITS, 32'h0000_1E7F);
    c.on_off_control = 1'b1;
    setc(srd_pkg::SP_LOCAL, srd_pkg::PV_INPUT_ONE);
    apb(1'b1, srd_pkg::ADDR_LIMITS, 32'h0000_0000);
    apb(1'b0, srd_pkg::ADDR_LIMITS, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    test_done();
  end
endmodule : setpoint_ramp_dwell_config_tb

// ===== tb/srd_plant.sv
// Purpose: Process plant feeding input one
// Assumes: Any heat output warms the process
// Notes: Load sets a fixed condition at once
`timescale 1ns/100ps
module srd_plant (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic [6:0] heat,
  // Sensor
  output logic [15:0] pv
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pv <= 16'h0000;
    else if (load)
      pv <= load_val;
    else if (heat != 7'h00)
      pv <= pv + 16'h0001;
  end
endmodule : srd_plant

// ===== tb/srd_top_props.sv
// Purpose: Port assertions for srd_top
// Assumes: Manipulated values stay at most 100
// Notes: Bound below the module
`timescale 1ns/100ps
module srd_top_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Observed
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [6:0] heat_manipulated_value,
  input wire logic manual_or_failure,
  input wire logic [6:0] heat_power_out,
  input wire logic [6:0] cool_power_out,
  input wire logic [3:0] config_error,
  input wire logic comm_enable,
  input wire logic link_point_to_point,
  input wire logic [7:0] unit_address
);
  logic wr;
  assign wr = psel && penable && pready && pwrite;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  apb_err_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  heat_cap_a: assert property (heat_power_out <= 7'h64)
    else $error("heat above full");
  cool_cap_a: assert property (cool_power_out <= 7'h64)
    else $error("cool above full");
  manual_pass_a: assert property (manual_or_failure |=>
    heat_power_out == $past(heat_manipulated_value))
    else $error("manual value limited");
  cfg_err_a: assert property ($changed(config_error) |-> $past(wr) || $past(wr, 2))
    else $error("error code without write");
  link_cfg_a: assert property ($changed({comm_enable, link_point_to_point})
    |-> $past(wr) || $past(wr, 2))
    else $error("link change without write");
  addr_range_a: assert property ($past(presetn) |->
    unit_address != 8'h00 && unit_address <= 8'hF7)
    else $error("unit address out of range");
endmodule : srd_top_props
bind srd_top srd_top_props u_props (.*);
